// File: include/sif_consts.svh
// Constants for the stepper discrete-input function logic.
`ifndef SIF_CONSTS_SVH
`define SIF_CONSTS_SVH
`define SIF_NUM_IN 2
`define SIF_CLK_HZ 25000000
`define SIF_FLASH_HALF_MS 250
`define SIF_FLASH_HALF_CYC (`SIF_CLK_HZ / 1000 * `SIF_FLASH_HALF_MS)
`define SIF_DEFAULT_ADDR 7'h61
`define SIF_POS_W 32
`define SIF_ADDR_W 7
`endif

// File: include/sif_pkg.sv
// Types for the stepper discrete-input function logic.
package sif_pkg;
    typedef enum logic [2:0] {
        SIF_FN_GP = 3'h0,
        SIF_FN_START_IDX = 3'h1,
        SIF_FN_ESTOP = 3'h2,
        SIF_FN_STOP_JOG = 3'h3,
        SIF_FN_HOME = 3'h4,
        SIF_FN_CW_LIMIT = 3'h5,
        SIF_FN_CCW_LIMIT = 3'h6
    } sif_func_t;
    typedef enum logic [2:0] {
        SIF_IND_NORMAL = 3'h0,
        SIF_IND_NOCOMM = 3'h1,
        SIF_IND_NOCFG = 3'h2,
        SIF_IND_PARAM = 3'h3,
        SIF_IND_NEWADDR = 3'h4,
        SIF_IND_ADDRFAIL = 3'h5,
        SIF_IND_FATAL = 3'h6
    } sif_ind_t;
endpackage

// File: rtl/sif_input_logic.sv
// Discrete-input function decoding and status indicator encoding.
`timescale 1ns/1ns
`default_nettype none
`include "sif_consts.svh"

module sif_input_logic
    import sif_pkg::*;
#(
    parameter int unsigned FLASH_HALF_CYC = `SIF_FLASH_HALF_CYC
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    input wire logic [`SIF_NUM_IN-1:0] din_in,
    input wire logic [`SIF_NUM_IN-1:0] cfg_active_high_in,
    input wire logic [2:0] cfg_func0_in,
    input wire logic [2:0] cfg_func1_in,
    input wire logic encoder_present_in,
    input wire logic [`SIF_POS_W-1:0] enc_pos_in,
    input wire logic move_pending_in,
    input wire logic move_active_in,
    input wire logic move_is_jog_reg_in,
    input wire logic drv_enable_req_in,
    input wire logic data_exchange_in,
    input wire logic cfg_received_in,
    input wire logic comm_timeout_in,
    input wire logic param_error_in,
    input wire logic new_addr_in,
    input wire logic addr_read_fail_in,
    input wire logic fatal_error_in,
    input wire logic [`SIF_ADDR_W-1:0] stored_addr_in,
    output logic start_move_out,
    output logic hard_stop_out,
    output logic move_inhibit_out,
    output logic soft_stop_out,
    output logic driver_enable_out,
    output logic enc_latch_out,
    output logic [`SIF_POS_W-1:0] latched_pos_out,
    output logic [`SIF_NUM_IN-1:0] gp_state_out,
    output logic [`SIF_ADDR_W-1:0] station_addr_out,
    output logic network_state_indicator_out,
    output logic module_state_indicator_out
);
    logic [`SIF_NUM_IN-1:0] lvl_v;
    logic [`SIF_NUM_IN-1:0] rise_v;
    logic [`SIF_NUM_IN-1:0] fall_v;
    logic [`SIF_NUM_IN-1:0] is_start;
    logic [`SIF_NUM_IN-1:0] is_estop;
    logic [`SIF_NUM_IN-1:0] is_stopjog;
    logic [`SIF_NUM_IN-1:0] is_gp;

    // Sync flops reset low; hold levels inactive until real samples arrive.
    logic [1:0] warm;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            warm <= 2'h0;
        end else if (clk_en_in) begin
            warm <= {warm[0], 1'b1};
        end
    end

    genvar gi;
    for (gi = 0; gi < `SIF_NUM_IN; gi++) begin : g_in
        logic s1;
        logic s2;
        logic lv;
        logic lvd;
        sif_func_t fn;
        assign fn = sif_func_t'((gi == 0) ? cfg_func0_in : cfg_func1_in);
        // The first stage is read only by the second; pins are asynchronous.
        always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                s1 <= 1'b0;
                s2 <= 1'b0;
                lv <= 1'b0;
                lvd <= 1'b0;
            end else if (clk_en_in) begin
                s1 <= din_in[gi];
                s2 <= s1;
                lv <= warm[1] & (s2 ~^ cfg_active_high_in[gi]);
                lvd <= lv;
            end
        end
        assign lvl_v[gi] = lv;
        assign rise_v[gi] = lv & ~lvd;
        assign fall_v[gi] = ~lv & lvd;
        assign is_start[gi] = (fn == SIF_FN_START_IDX);
        assign is_estop[gi] = (fn == SIF_FN_ESTOP);
        assign is_stopjog[gi] = (fn == SIF_FN_STOP_JOG);
        assign is_gp[gi] = (fn == SIF_FN_GP);
    end

    logic start_ev;
    logic start_any_edge;
    logic estop_lvl;
    logic stop_ev;
    logic jog_run;
    logic latch_ev;

    assign start_ev = |(rise_v & is_start);
    assign start_any_edge = |((rise_v | fall_v) & is_start);
    assign estop_lvl = |(lvl_v & is_estop);
    assign stop_ev = |(rise_v & is_stopjog);
    assign jog_run = move_active_in & move_is_jog_reg_in;
    // A stop edge outside a jog or registration move latches nothing.
    assign latch_ev = encoder_present_in
        & (start_any_edge | (stop_ev & jog_run));

    // Motion commands.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            start_move_out <= 1'b0;
            hard_stop_out <= 1'b0;
            move_inhibit_out <= 1'b0;
            soft_stop_out <= 1'b0;
            driver_enable_out <= 1'b0;
        end else if (clk_en_in) begin
            start_move_out <= start_ev & move_pending_in
                & ~estop_lvl;
            hard_stop_out <= estop_lvl;
            move_inhibit_out <= estop_lvl;
            soft_stop_out <= stop_ev & jog_run;
            // Halting must not drop holding torque, so the enable ignores it.
            driver_enable_out <= drv_enable_req_in;
        end
    end

    // Encoder capture.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            enc_latch_out <= 1'b0;
            latched_pos_out <= 32'h0000_0000;
        end else if (clk_en_in) begin
            enc_latch_out <= latch_ev;
            if (latch_ev) begin
                latched_pos_out <= enc_pos_in;
            end
        end
    end

    // General-purpose reporting; other functions read as zero here.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gp_state_out <= 2'h0;
        end else if (clk_en_in) begin
            gp_state_out <= lvl_v & is_gp;
        end
    end

    // Sticky conditions; only a power cycle (reset) clears them.
    logic fatal;
    logic addr_fail;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fatal <= 1'b0;
            addr_fail <= 1'b0;
            station_addr_out <= 7'h00;
        end else if (clk_en_in) begin
            fatal <= fatal | fatal_error_in;
            addr_fail <= addr_fail | addr_read_fail_in;
            station_addr_out <= (addr_fail | addr_read_fail_in)
                ? `SIF_DEFAULT_ADDR : stored_addr_in;
        end
    end

    // Flash timebase.
    logic [31:0] flash_cnt;
    logic flash;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            flash_cnt <= 32'h0000_0000;
            flash <= 1'b0;
        end else if (clk_en_in) begin
            if (flash_cnt >= FLASH_HALF_CYC - 1) begin
                flash_cnt <= 32'h0000_0000;
                flash <= ~flash;
            end else begin
                flash_cnt <= flash_cnt + 32'h0000_0001;
            end
        end
    end

    // Indicator state, highest priority first.
    sif_ind_t ind_st;
    sif_ind_t next_ind_st;
    always_comb begin
        if (fatal | fatal_error_in) begin
            next_ind_st = SIF_IND_FATAL;
        end else if (addr_fail | addr_read_fail_in) begin
            next_ind_st = SIF_IND_ADDRFAIL;
        end else if (new_addr_in) begin
            next_ind_st = SIF_IND_NEWADDR;
        end else if (param_error_in) begin
            next_ind_st = SIF_IND_PARAM;
        end else if (!cfg_received_in) begin
            next_ind_st = SIF_IND_NOCFG;
        end else if (data_exchange_in & ~comm_timeout_in) begin
            next_ind_st = SIF_IND_NORMAL;
        end else begin
            next_ind_st = SIF_IND_NOCOMM;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ind_st <= SIF_IND_NOCFG;
        end else if (clk_en_in) begin
            ind_st <= next_ind_st;
        end
    end

    // Reset drives both indicators off, matching the unpowered look.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            network_state_indicator_out <= 1'b0;
            module_state_indicator_out <= 1'b0;
        end else if (clk_en_in) begin
            unique case (ind_st)
                SIF_IND_NORMAL: begin
                    network_state_indicator_out <= 1'b0;
                    module_state_indicator_out <= 1'b1;
                end
                SIF_IND_NOCOMM: begin
                    network_state_indicator_out <= 1'b1;
                    module_state_indicator_out <= 1'b0;
                end
                SIF_IND_NOCFG: begin
                    network_state_indicator_out <= 1'b1;
                    module_state_indicator_out <= 1'b1;
                end
                SIF_IND_PARAM: begin
                    network_state_indicator_out <= 1'b1;
                    module_state_indicator_out <= flash;
                end
                SIF_IND_NEWADDR: begin
                    network_state_indicator_out <= flash;
                    module_state_indicator_out <= 1'b1;
                end
                SIF_IND_ADDRFAIL: begin
                    network_state_indicator_out <= flash;
                    module_state_indicator_out <= flash;
                end
                SIF_IND_FATAL: begin
                    network_state_indicator_out <= flash;
                    module_state_indicator_out <= ~flash;
                end
                default: begin
                    network_state_indicator_out <= 1'b1;
                    module_state_indicator_out <= 1'b1;
                end
            endcase
        end
    end

    // Checks.
    start_gate_a: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        $rose(start_move_out) |->
            $past(move_pending_in) && !$past(estop_lvl))
        else $error("Move started without pending move or during halt.");
    estop_halt_a: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        clk_en_in && estop_lvl |=> hard_stop_out && move_inhibit_out)
        else $error("Emergency halt not applied in one cycle.");
    drv_keep_a: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        clk_en_in && drv_enable_req_in && estop_lvl |=> driver_enable_out)
        else $error("Driver disabled by emergency halt.");
    no_start_halt_a: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        move_inhibit_out |-> !start_move_out)
        else $error("Start issued while halted.");
    soft_stop_a: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        clk_en_in && stop_ev |=> soft_stop_out == $past(jog_run))
        else $error("Controlled stop wrong for move type.");
    latch_val_a: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        clk_en_in && latch_ev |=>
            enc_latch_out && latched_pos_out == $past(enc_pos_in))
        else $error("Encoder position not captured.");
    latch_jog_a: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        clk_en_in && !start_any_edge && !jog_run |=> !enc_latch_out)
        else $error("Capture outside jog or registration move.");
    gp_report_a: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        clk_en_in && (is_gp != 2'h0) |=>
            (gp_state_out & $past(is_gp)) == ($past(lvl_v) & $past(is_gp)))
        else $error("General-purpose state not reported.");
    ind_normal_a: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        clk_en_in && ind_st == SIF_IND_NORMAL |=>
            !network_state_indicator_out && module_state_indicator_out)
        else $error("Normal indicator pattern wrong.");
    addr_def_a: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        clk_en_in && addr_fail |=> station_addr_out == 7'h61)
        else $error("Default station address not used.");
    fatal_alt_a: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        clk_en_in && ind_st == SIF_IND_FATAL |=>
            network_state_indicator_out != module_state_indicator_out)
        else $error("Fatal pattern not alternating.");
    fatal_hold_a: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        fatal |=> fatal)
        else $error("Fatal condition cleared without reset.");

    start_c: cover property (@(posedge sys_clk_in) $rose(start_move_out));
    stop_c: cover property (@(posedge sys_clk_in) $rose(soft_stop_out));
    halt_c: cover property (@(posedge sys_clk_in) $rose(hard_stop_out));
    latch_c: cover property (@(posedge sys_clk_in) $rose(enc_latch_out));
endmodule
`default_nettype wire

// File: testbench/sif_sensor_model.sv
// Field contacts wired to the two discrete inputs of the block.
`timescale 1ns/1ns
`default_nettype none
module sif_sensor_model (
    input wire logic sys_clk_in,
    input wire logic [1:0] active_in,
    input wire logic [1:0] active_high_in,
    output logic [1:0] din_out
);
    // A contact moves just after a clock edge, never on the sampling edge.
    // An actuated normally closed contact opens, so its pin reads low.
    always_ff @(posedge sys_clk_in) begin
        din_out <= active_in ~^ active_high_in;
    end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the discrete-input function logic.
`timescale 1ns/1ns
`default_nettype none
`include "sif_consts.svh"
module testbench;
    import sif_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, enc = 0, pend = 0, mv = 0, jog = 0;
    logic drv = 0;
    // Polarity stays fixed: changing it live would fake an input edge.
    logic [1:0] ah = 2'b01, act = 2'b00, din, gp, frz;
    logic [2:0] f0 = SIF_FN_GP, f1 = SIF_FN_GP;
    logic [6:0] stv = 7'h00, addr = 7'h00, sa;
    logic [31:0] pos = 32'h0000_0000, lp;
    logic sm_o, hs, mi, ss, de, lt, ns, ms;
    logic [34:0] exp_q[$];
    logic [34:0] e;
    int num_errors = 0, checks = 0;
    always #20 clk = ~clk;
    sif_sensor_model sensors (.sys_clk_in(clk), .active_in(act),
        .active_high_in(ah), .din_out(din));
    sif_input_logic #(.FLASH_HALF_CYC(4)) dut (.sys_clk_in(clk),
        .arst_n_in(rst_n), .clk_en_in(ce), .din_in(din),
        .cfg_active_high_in(ah), .cfg_func0_in(f0), .cfg_func1_in(f1),
        .encoder_present_in(enc), .enc_pos_in(pos), .move_pending_in(pend),
        .move_active_in(mv), .move_is_jog_reg_in(jog),
        .drv_enable_req_in(drv), .data_exchange_in(stv[0]),
        .cfg_received_in(stv[1]), .comm_timeout_in(stv[2]),
        .param_error_in(stv[3]), .new_addr_in(stv[4]),
        .addr_read_fail_in(stv[5]), .fatal_error_in(stv[6]),
        .stored_addr_in(addr), .start_move_out(sm_o), .hard_stop_out(hs),
        .move_inhibit_out(mi), .soft_stop_out(ss), .driver_enable_out(de),
        .enc_latch_out(lt), .latched_pos_out(lp), .gp_state_out(gp),
        .station_addr_out(sa), .network_state_indicator_out(ns),
        .module_state_indicator_out(ms));
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Moves one contact and notes the pulses it should cause.
    task automatic ev(input int i, input logic a, s, t, l);
        logic [31:0] p;
        p = $urandom;
        @(posedge clk);
        pos <= p;
        act[i] <= a;
        if (s | t | l) begin
            exp_q.push_back({s, t, l, p});
        end
        repeat (8) @(posedge clk);
    endtask
    // Watches the indicators for three flash periods after a status change.
    task automatic ind(input logic [6:0] v, input logic [1:0] en_, em, rel);
        logic [1:0] sn, sm, r;
        sn = 2'b00;
        sm = 2'b00;
        r = 2'b11;
        @(posedge clk);
        stv <= v;
        repeat (3) @(negedge clk);
        repeat (24) begin
            @(negedge clk);
            sn[ns] = 1'b1;
            sm[ms] = 1'b1;
            if (ns !== ms) r[1] = 1'b0;
            if (ns === ms) r[0] = 1'b0;
        end
        chk("network_seen", {30'h0, sn}, {30'h0, en_});
        chk("module_seen", {30'h0, sm}, {30'h0, em});
        chk("indicator_relation", {30'h0, r}, {30'h0, rel});
    endtask
    // Every pulse must match the oldest note; an unnoted pulse is an error.
    always @(negedge clk) begin
        if (rst_n && (sm_o | ss | lt) === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected_pulse", {sm_o, ss, lt}, 0);
            end else begin
                e = exp_q.pop_front();
                chk("pulses", {sm_o, ss, lt}, e[34:32]);
                if (e[32]) chk("latched_pos", lp, e[31:0]);
            end
        end
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial begin
        void'($urandom(32'h3a7554b0));
        addr <= 7'($urandom);
        repeat (3) @(posedge clk);
        chk("ns_in_reset", ns, 0);
        chk("ms_in_reset", ms, 0);
        rst_n <= 1;
        f0 <= SIF_FN_START_IDX;
        enc <= 1;
        pend <= 1;
        repeat (4) @(posedge clk);
        chk("station_addr", sa, addr);
        ev(0, 1, 1, 0, 1);
        ev(1, 1, 0, 0, 0);
        chk("gp_state", gp, 2'b10);
        ev(1, 0, 0, 0, 0);
        ev(0, 0, 0, 0, 1);
        pend <= 0;
        ev(0, 1, 0, 0, 1);
        ev(0, 0, 0, 0, 1);
        enc <= 0;
        pend <= 1;
        ev(0, 1, 1, 0, 0);
        ev(0, 0, 0, 0, 0);
        enc <= 1;
        f1 <= SIF_FN_ESTOP;
        drv <= 1;
        ev(1, 1, 0, 0, 0);
        chk("hard_stop", hs, 1);
        chk("move_inhibit", mi, 1);
        chk("driver_enable", de, 1);
        ev(0, 1, 0, 0, 1);
        ev(0, 0, 0, 0, 1);
        ev(1, 0, 0, 0, 0);
        chk("hard_stop_off", hs, 0);
        chk("move_inhibit_off", mi, 0);
        f1 <= SIF_FN_STOP_JOG;
        mv <= 1;
        jog <= 1;
        ev(1, 1, 0, 1, 1);
        ev(1, 0, 0, 0, 0);
        jog <= 0;
        ev(1, 1, 0, 0, 0);
        ev(1, 0, 0, 0, 0);
        f0 <= SIF_FN_GP;
        ev(0, 1, 0, 0, 0);
        chk("gp_state", gp, 2'b01);
        ev(0, 0, 0, 0, 0);
        ind(7'h00, 2'b10, 2'b10, 2'b10);
        ind(7'h03, 2'b01, 2'b10, 2'b01);
        ind(7'h07, 2'b10, 2'b01, 2'b01);
        ind(7'h0b, 2'b10, 2'b11, 2'b00);
        ind(7'h13, 2'b11, 2'b10, 2'b00);
        ind(7'h23, 2'b11, 2'b11, 2'b10);
        ind(7'h03, 2'b11, 2'b11, 2'b10);
        chk("station_addr", sa, 7'h61);
        ind(7'h43, 2'b11, 2'b11, 2'b01);
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        frz = {ns, ms};
        repeat (10) @(posedge clk);
        chk("frozen_indicators", {30'h0, ns, ms}, {30'h0, frz});
        ce <= 1'b1;
        ind(7'h03, 2'b11, 2'b11, 2'b01);
        chk("notes_left", exp_q.size(), 0);
        final_report();
    end
endmodule
`default_nettype wire
